// file: hw/fault_defs.svh
// offsets, field positions, reset values, limits and timing of the fault supervisor
`ifndef FAULT_DEFS_SVH
`define FAULT_DEFS_SVH

`define OFS_CONFIG 8'h00
`define OFS_CMD 8'h04
`define OFS_SER_TMO 8'h08
`define OFS_OPT_TMO 8'h0C
`define OFS_ILIM 8'h10
`define OFS_ILIM_DELAY 8'h14
`define OFS_RATED 8'h18
`define OFS_WARN 8'h1C
`define OFS_ALARM 8'h20
`define OFS_ADAPT 8'h24

`define CFG_CLASS_LSB 0
`define CFG_MOTOR_ALARM 2
`define CFG_SEALED 3
`define CFG_SERFN_LSB 4
`define CFG_OPTFN_LSB 7
`define CFG_AUTORST 10
`define CFG_RESET 11'h000
`define TMO_RESET 16'h03E8
`define ILIM_RESET 16'hFFFF
`define ILIM_DELAY_RESET 16'h03E8
`define RATED_RESET 32'h0000_0000

`define CMD_RESET 0
`define CMD_ADAPT 1

`define FN_OFF 3'h0
`define FN_STOP_TRIP 3'h5

// alarm bit positions
`define AL_OV 0
`define AL_UV 1
`define AL_INV 2
`define AL_MOTOR 3
`define AL_THERM 4
`define AL_ILIM 5
`define AL_OC 6
`define AL_EARTH 7
`define AL_SHORT 8
`define AL_SERIAL 9
`define AL_OPTION 10
`define AL_ADAPT 11
`define AL_HEAT 12
`define AL_PHASE_U 13
`define AL_PHASE_V 14
`define LOCKED_MASK 16'h01C0

// warning bit positions
`define WN_OV 0
`define WN_UV 1
`define WN_INV 2
`define WN_MOTOR 3
`define WN_THERM 4
`define WN_ILIM 5
`define WN_OC 6
`define WN_VHIGH 7
`define WN_VLOW 8
`define WN_SERIAL 9
`define WN_OPTION 10
`define WN_PNVM 11
`define WN_CNVM 12

// bus voltage limits in VDC: low, middle, high supply class
`define UV_LOW 12'h0D3
`define UV_MID 12'h192
`define UV_HIGH 12'h22D
`define WL_LOW 12'h0DE
`define WL_MID 12'h1A7
`define WL_HIGH 12'h249
`define WH_LOW 12'h180
`define WH_MID 12'h301
`define WH_HIGH 12'h3AF
`define OV_LOW 12'h1A9
`define OV_MID 12'h357
`define OV_HIGH 12'h3CF

// percent and degree figures
`define PCT_WARN 8'h62
`define PCT_FULL 8'h64
`define PCT_RELEASE 8'h5A
`define PCT_ADAPT_MIN 8'h23
`define TEMP_OPEN 8'h5A
`define TEMP_SEALED 8'h50
`define TEMP_RELEASE 8'h3C

// timing; trip delays are counted in millisecond ticks
`define CLK_PERIOD_NS 32'h0000_000A
`define TICK_PERIOD_NS 32'h000F_4240
`define OV_DELAY_MS 16'h000A
`define UV_DELAY_MS 16'h000A
`define OC_DELAY_MS 16'h05DC

`endif

// file: hw/fault_pkg.sv
// types shared by the fault supervisor
package fault_pkg;
	typedef enum logic [1:0] {CLASS_LOW, CLASS_MID, CLASS_HIGH} supply_class_t;
	typedef enum logic [3:0] {CAUSE_PARAM, CAUSE_LOW_CURRENT, CAUSE_ASYMMETRY, CAUSE_TOO_BIG, CAUSE_TOO_SMALL,
		CAUSE_TIMEOUT, CAUSE_USER, CAUSE_INTERNAL, CAUSE_LIMIT, CAUSE_ROTATING} adapt_code_t;
	typedef enum logic [1:0] {BUS_IDLE, BUS_RAMP, BUS_TRIP} bus_state_t;
	typedef enum logic {ADAPT_IDLE, ADAPT_RUN} adapt_state_t;
	typedef enum logic [1:0] {LIM_UNDER, LIM_WARN_LOW, LIM_WARN_HIGH, LIM_OVER} volt_limit_t;
endpackage

// file: hw/trip_timer.sv
// delay timer: flags expiry once its condition has held for limit ticks
`timescale 1ns/1ps
module trip_timer #(
	parameter int WIDTH = 16
)
(
	input wire logic clock,
	input wire logic rstnSync,
	input wire logic tick,
	input wire logic active,
	input wire logic [WIDTH-1:0] limit,
	output logic expired
);
	logic [WIDTH-1:0] count_reg;
	logic [WIDTH-1:0] count_next;
	logic reached;

	// a dropped condition restarts the delay from zero
	assign reached = (count_reg >= limit);
	assign count_next = !active ? '0 : (tick && !reached) ? count_reg + 1'b1 : count_reg;

	always_ff @(posedge clock or negedge rstnSync)
	begin
		if (!rstnSync)
		begin
			count_reg <= '0;
			expired <= 1'b0;
		end
		else
		begin
			count_reg <= count_next;
			expired <= active && reached;
		end
	end
endmodule

// file: hw/drive_fault_supervisor.sv
// fault supervisor of the drive: warnings, latched alarms, trips and APB registers
`timescale 1ns/1ps
`include "fault_defs.svh"

// How it works
// - overvoltage warns, trips after fixed delay
// - undervoltage warns, trips after fixed delay
// - trip voltage limits chosen by supply class
// - warning voltage limits by class, no trip
// - inverter counter warns 98, trips 100
// - inverter trip reset blocked at 90 and above
// - motor thermal 100 gives warning or alarm
// - open thermistor: warning or alarm likewise
// - current limit warns, trips after delay
// - peak over 200% warns, trips later
// - earth fault alarms at once
// - output short alarms at once
// - serial timeout warns when function not off
// - stop-and-trip: alarm, ramp down, trip
// - option bus timeout supervised the same way
// - power memory fault only warns
// - control memory fault only warns
// - adaptation alarm carries cause 0 to 9
// - adaptation refused while any alarm
// - adaptation needs motor current above 35%
// - heat sink trips at 90 or 80
// - heat sink reset blocked at 60 and above
// - separate alarms for missing U and V
// - key, input, command or auto reset
module drive_fault_supervisor #(
	parameter int TICK_CYCLES = `TICK_PERIOD_NS / `CLK_PERIOD_NS,
	parameter logic [15:0] OV_DELAY = `OV_DELAY_MS,
	parameter logic [15:0] UV_DELAY = `UV_DELAY_MS,
	parameter logic [15:0] OC_DELAY = `OC_DELAY_MS
)
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [11:0] busVoltage,
	input wire logic [15:0] outputCurrent,
	input wire logic [15:0] peakCurrent,
	input wire logic [7:0] invThermal,
	input wire logic [7:0] motorThermal,
	input wire logic [7:0] heatsinkTemp,
	input wire logic thermistorOpen,
	input wire logic earthFault,
	input wire logic outputShort,
	input wire logic phaseUMissing,
	input wire logic phaseVMissing,
	input wire logic powerNvmFault,
	input wire logic controlNvmFault,
	input wire logic serialActivity,
	input wire logic optionActivity,
	input wire logic resetKey,
	input wire logic resetInput,
	input wire logic rampDone,
	input wire logic adaptDone,
	input wire logic adaptFail,
	input wire fault_pkg::adapt_code_t adaptResult,
	output logic driveEnable,
	output logic rampDown,
	output logic adaptRun,
	output fault_pkg::adapt_code_t adaptCause,
	output logic [15:0] warnings,
	output logic [15:0] alarms
);
	import fault_pkg::*;

	localparam int TICK_W = $clog2(TICK_CYCLES + 1);
	localparam int PIN_W = 86;

	function automatic logic [11:0] voltLimit(supply_class_t cls, volt_limit_t kind);
		logic [11:0] lim;
		lim = 12'h000;
		case (kind)
			LIM_UNDER: lim = (cls == CLASS_HIGH) ? `UV_HIGH : (cls == CLASS_MID) ? `UV_MID : `UV_LOW;
			LIM_WARN_LOW: lim = (cls == CLASS_HIGH) ? `WL_HIGH : (cls == CLASS_MID) ? `WL_MID : `WL_LOW;
			LIM_WARN_HIGH: lim = (cls == CLASS_HIGH) ? `WH_HIGH : (cls == CLASS_MID) ? `WH_MID : `WH_LOW;
			LIM_OVER: lim = (cls == CLASS_HIGH) ? `OV_HIGH : (cls == CLASS_MID) ? `OV_MID : `OV_LOW;
			default: lim = 12'h000;
		endcase
		return lim;
	endfunction

	function automatic bus_state_t busStep(bus_state_t s, logic go, logic done, logic latched);
		bus_state_t n;
		n = s;
		case (s)
			BUS_IDLE: n = go ? BUS_RAMP : BUS_IDLE;
			BUS_RAMP: n = done ? BUS_TRIP : BUS_RAMP;
			BUS_TRIP: n = latched ? BUS_TRIP : BUS_IDLE;
			default: n = BUS_IDLE;
		endcase
		return n;
	endfunction

	// reset release and pin synchronisers
	logic rstA_reg;
	logic rstnSync;
	logic [PIN_W-1:0] pinA_reg;
	logic [PIN_W-1:0] pinB_reg;
	logic [PIN_W-1:0] pinRaw;

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			rstA_reg <= 1'b0;
			rstnSync <= 1'b0;
		end
		else
		begin
			rstA_reg <= 1'b1;
			rstnSync <= rstA_reg;
		end
	end

	// multi-bit readings are sampled words; a torn sample lasts one cycle, absorbed only where a trip delay follows
	assign pinRaw = {busVoltage, outputCurrent, peakCurrent, invThermal, motorThermal, heatsinkTemp,
		thermistorOpen, earthFault, outputShort, phaseUMissing, phaseVMissing, powerNvmFault, controlNvmFault,
		serialActivity, optionActivity, resetKey, resetInput, rampDone, adaptDone, adaptFail, adaptResult};

	always_ff @(posedge clock or negedge rstnSync)
	begin
		if (!rstnSync)
		begin
			pinA_reg <= '0;
			pinB_reg <= '0;
		end
		else
		begin
			pinA_reg <= pinRaw;
			pinB_reg <= pinA_reg;
		end
	end

	logic [11:0] volt;
	logic [15:0] curr;
	logic [15:0] peak;
	logic [7:0] invPct;
	logic [7:0] motPct;
	logic [7:0] heat;
	logic thermOpen, earth, short, phU, phV, pNvm, cNvm, serAct, optAct, keyLvl, inLvl, rampOk, doneLvl, failLvl;
	adapt_code_t resultCode;

	assign {volt, curr, peak, invPct, motPct, heat, thermOpen, earth, short, phU, phV, pNvm, cNvm,
		serAct, optAct, keyLvl, inLvl, rampOk, doneLvl, failLvl} = pinB_reg[PIN_W-1:4];
	assign resultCode = adapt_code_t'(pinB_reg[3:0]);

	// software registers
	logic [10:0] cfg_reg;
	logic [15:0] serTmo_reg;
	logic [15:0] optTmo_reg;
	logic [15:0] ilim_reg;
	logic [15:0] ilimDelay_reg;
	logic [31:0] rated_reg;
	logic [15:0] alarm_reg, alarm_next;
	logic [15:0] warn_reg, warn_next;
	logic [TICK_W-1:0] tick_reg;
	logic [2:0] edge_reg;
	bus_state_t ser_reg, opt_reg;
	adapt_state_t adapt_reg, adapt_next;
	adapt_code_t cause_reg, cause_next;
	logic refused_reg, refused_next;

	supply_class_t cls;
	logic motorAsAlarm, sealed, autoRst;
	logic [2:0] serFn, optFn;
	assign cls = supply_class_t'(cfg_reg[`CFG_CLASS_LSB+:2]);
	assign motorAsAlarm = cfg_reg[`CFG_MOTOR_ALARM];
	assign sealed = cfg_reg[`CFG_SEALED];
	assign serFn = cfg_reg[`CFG_SERFN_LSB+:3];
	assign optFn = cfg_reg[`CFG_OPTFN_LSB+:3];
	assign autoRst = cfg_reg[`CFG_AUTORST];

	// APB decode; the slave never waits
	logic setup, wrEn, hitCfg, hitCmd, hitSer, hitOpt, hitIlim, hitDly, hitRated, hitWarn, hitAlarm, hitAdapt, mapped;
	assign setup = psel && !penable;
	assign wrEn = psel && penable && pwrite;
	assign hitCfg = (paddr == `OFS_CONFIG);
	assign hitCmd = (paddr == `OFS_CMD);
	assign hitSer = (paddr == `OFS_SER_TMO);
	assign hitOpt = (paddr == `OFS_OPT_TMO);
	assign hitIlim = (paddr == `OFS_ILIM);
	assign hitDly = (paddr == `OFS_ILIM_DELAY);
	assign hitRated = (paddr == `OFS_RATED);
	assign hitWarn = (paddr == `OFS_WARN);
	assign hitAlarm = (paddr == `OFS_ALARM);
	assign hitAdapt = (paddr == `OFS_ADAPT);
	assign mapped = hitCfg | hitCmd | hitSer | hitOpt | hitIlim | hitDly | hitRated | hitWarn | hitAlarm | hitAdapt;
	assign pready = 1'b1;

	logic [31:0] readMux;
	assign readMux = hitCfg ? {21'h00_0000, cfg_reg} :
		hitSer ? {16'h0000, serTmo_reg} :
		hitOpt ? {16'h0000, optTmo_reg} :
		hitIlim ? {16'h0000, ilim_reg} :
		hitDly ? {16'h0000, ilimDelay_reg} :
		hitRated ? rated_reg :
		hitWarn ? {16'h0000, warn_reg} :
		hitAlarm ? {16'h0000, alarm_reg} :
		hitAdapt ? {26'h000_0000, adapt_reg == ADAPT_RUN, refused_reg, cause_reg} : 32'h0000_0000;

	always_ff @(posedge clock or negedge rstnSync)
	begin
		if (!rstnSync)
		begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else if (setup)
		begin
			prdata <= pwrite ? 32'h0000_0000 : readMux;
			pslverr <= !mapped;
		end
	end

	always_ff @(posedge clock or negedge rstnSync)
	begin
		if (!rstnSync)
		begin
			cfg_reg <= `CFG_RESET;
			serTmo_reg <= `TMO_RESET;
			optTmo_reg <= `TMO_RESET;
			ilim_reg <= `ILIM_RESET;
			ilimDelay_reg <= `ILIM_DELAY_RESET;
			rated_reg <= `RATED_RESET;
		end
		else if (wrEn)
		begin
			if (hitCfg) cfg_reg <= pwdata[10:0];
			if (hitSer) serTmo_reg <= pwdata[15:0];
			if (hitOpt) optTmo_reg <= pwdata[15:0];
			if (hitIlim) ilim_reg <= pwdata[15:0];
			if (hitDly) ilimDelay_reg <= pwdata[15:0];
			if (hitRated) rated_reg <= pwdata;
		end
	end

	logic cmdReset, cmdAdapt;
	assign cmdReset = wrEn && hitCmd && pwdata[`CMD_RESET];
	assign cmdAdapt = wrEn && hitCmd && pwdata[`CMD_ADAPT];

	// millisecond tick for all trip delays
	logic tick;
	assign tick = (tick_reg == TICK_W'(TICK_CYCLES - 1));

	// measurement comparisons
	logic overV, underV, highV, lowV, overI, overPeak, serTmo, optTmo, serOn, optOn;
	logic [16:0] peakLimit;
	assign overV = volt > voltLimit(cls, LIM_OVER);
	assign underV = volt < voltLimit(cls, LIM_UNDER);
	assign highV = volt > voltLimit(cls, LIM_WARN_HIGH);
	assign lowV = volt < voltLimit(cls, LIM_WARN_LOW);
	assign overI = curr > ilim_reg;
	assign peakLimit = {rated_reg[31:16], 1'b0};
	assign overPeak = {1'b0, peak} > peakLimit;
	assign serOn = (serFn != `FN_OFF);
	assign optOn = (optFn != `FN_OFF);

	logic ovTrip, uvTrip, ilimTrip, ocTrip;
	trip_timer #(.WIDTH(16)) ovTimer (.clock(clock), .rstnSync(rstnSync), .tick(tick), .active(overV),
		.limit(OV_DELAY), .expired(ovTrip));
	trip_timer #(.WIDTH(16)) uvTimer (.clock(clock), .rstnSync(rstnSync), .tick(tick), .active(underV),
		.limit(UV_DELAY), .expired(uvTrip));
	trip_timer #(.WIDTH(16)) ilimTimer (.clock(clock), .rstnSync(rstnSync), .tick(tick), .active(overI),
		.limit(ilimDelay_reg), .expired(ilimTrip));
	trip_timer #(.WIDTH(16)) ocTimer (.clock(clock), .rstnSync(rstnSync), .tick(tick), .active(overPeak),
		.limit(OC_DELAY), .expired(ocTrip));
	trip_timer #(.WIDTH(16)) serTimer (.clock(clock), .rstnSync(rstnSync), .tick(tick),
		.active(serOn && !serAct), .limit(serTmo_reg), .expired(serTmo));
	trip_timer #(.WIDTH(16)) optTimer (.clock(clock), .rstnSync(rstnSync), .tick(tick),
		.active(optOn && !optAct), .limit(optTmo_reg), .expired(optTmo));

	// stop-and-trip: alarm raised in the same cycle the ramp starts, output kept alive for the ramp, trip once ramp is done
	logic serGo, optGo;
	bus_state_t serNext, optNext;
	assign serGo = serTmo && (serFn == `FN_STOP_TRIP);
	assign optGo = optTmo && (optFn == `FN_STOP_TRIP);
	assign serNext = busStep(ser_reg, serGo, rampOk, alarm_reg[`AL_SERIAL]);
	assign optNext = busStep(opt_reg, optGo, rampOk, alarm_reg[`AL_OPTION]);
	assign rampDown = (ser_reg == BUS_RAMP) || (opt_reg == BUS_RAMP);

	// adaptation start, refusal and result
	logic anyAlarm, ratioOk, startOk, ratioFail, doneRise, failRise, adaptAlarm;
	logic [23:0] motScaled, convScaled;
	assign anyAlarm = |alarm_reg;
	assign motScaled = 24'(rated_reg[15:0]) * 24'(`PCT_FULL);
	assign convScaled = 24'(rated_reg[31:16]) * 24'(`PCT_ADAPT_MIN);
	assign ratioOk = motScaled > convScaled;
	assign startOk = cmdAdapt && (adapt_reg == ADAPT_IDLE) && !anyAlarm;
	assign ratioFail = startOk && !ratioOk;
	assign doneRise = doneLvl && !edge_reg[0];
	assign failRise = failLvl && !edge_reg[1];
	assign adaptAlarm = ratioFail || ((adapt_reg == ADAPT_RUN) && failRise);
	assign adaptRun = (adapt_reg == ADAPT_RUN);

	always_comb
	begin
		adapt_next = adapt_reg;
		cause_next = cause_reg;
		refused_next = refused_reg;
		case (adapt_reg)
			ADAPT_IDLE:
			begin
				if (cmdAdapt && anyAlarm)
					refused_next = 1'b1;
				else if (ratioFail)
				begin
					refused_next = 1'b0;
					cause_next = CAUSE_LOW_CURRENT;
				end
				else if (startOk)
				begin
					refused_next = 1'b0;
					adapt_next = ADAPT_RUN;
				end
			end
			ADAPT_RUN:
			begin
				if (failRise)
				begin
					cause_next = resultCode;
					adapt_next = ADAPT_IDLE;
				end
				else if (doneRise)
					adapt_next = ADAPT_IDLE;
			end
			default: adapt_next = ADAPT_IDLE;
		endcase
	end

	// alarm sources
	logic [15:0] alarmSet;
	logic [7:0] heatLimit;
	assign heatLimit = sealed ? `TEMP_SEALED : `TEMP_OPEN;
	always_comb
	begin
		alarmSet = 16'h0000;
		alarmSet[`AL_OV] = ovTrip;
		alarmSet[`AL_UV] = uvTrip;
		alarmSet[`AL_INV] = invPct >= `PCT_FULL;
		alarmSet[`AL_MOTOR] = motorAsAlarm && (motPct >= `PCT_FULL);
		alarmSet[`AL_THERM] = motorAsAlarm && thermOpen;
		alarmSet[`AL_ILIM] = ilimTrip;
		alarmSet[`AL_OC] = ocTrip;
		alarmSet[`AL_EARTH] = earth;
		alarmSet[`AL_SHORT] = short;
		alarmSet[`AL_SERIAL] = serGo && (ser_reg == BUS_IDLE);
		alarmSet[`AL_OPTION] = optGo && (opt_reg == BUS_IDLE);
		alarmSet[`AL_ADAPT] = adaptAlarm;
		alarmSet[`AL_HEAT] = heat >= heatLimit;
		alarmSet[`AL_PHASE_U] = phU;
		alarmSet[`AL_PHASE_V] = phV;
	end

	// reset sources and per-alarm release conditions; locked alarms need a power cycle
	logic resetReq;
	logic [15:0] clearMask;
	assign resetReq = (keyLvl && !edge_reg[2]) || (inLvl && !edge_reg[2]) || cmdReset || (autoRst && tick);
	always_comb
	begin
		clearMask = ~`LOCKED_MASK;
		if (invPct >= `PCT_RELEASE)
			clearMask[`AL_INV] = 1'b0;
		if (heat >= `TEMP_RELEASE)
			clearMask[`AL_HEAT] = 1'b0;
	end

	// a new fault in the reset cycle stays latched
	assign alarm_next = (alarm_reg & ~(resetReq ? clearMask : 16'h0000)) | alarmSet;

	always_comb
	begin
		warn_next = 16'h0000;
		warn_next[`WN_OV] = overV;
		warn_next[`WN_UV] = underV;
		warn_next[`WN_INV] = invPct >= `PCT_WARN;
		warn_next[`WN_MOTOR] = !motorAsAlarm && (motPct >= `PCT_FULL);
		warn_next[`WN_THERM] = !motorAsAlarm && thermOpen;
		warn_next[`WN_ILIM] = overI;
		warn_next[`WN_OC] = overPeak;
		warn_next[`WN_VHIGH] = highV;
		warn_next[`WN_VLOW] = lowV;
		warn_next[`WN_SERIAL] = serOn && serTmo;
		warn_next[`WN_OPTION] = optOn && optTmo;
		warn_next[`WN_PNVM] = pNvm;
		warn_next[`WN_CNVM] = cNvm;
	end

	// a bus alarm in its ramp phase does not yet cut the output stage
	logic [15:0] rampMask;
	assign rampMask = {5'h00, opt_reg == BUS_RAMP, ser_reg == BUS_RAMP, 9'h000};
	assign driveEnable = !(|(alarm_reg & ~rampMask));
	assign alarms = alarm_reg;
	assign warnings = warn_reg;
	assign adaptCause = cause_reg;

	always_ff @(posedge clock or negedge rstnSync)
	begin
		if (!rstnSync)
		begin
			alarm_reg <= 16'h0000;
			warn_reg <= 16'h0000;
			tick_reg <= '0;
			edge_reg <= 3'h0;
			ser_reg <= BUS_IDLE;
			opt_reg <= BUS_IDLE;
			adapt_reg <= ADAPT_IDLE;
			cause_reg <= CAUSE_PARAM;
			refused_reg <= 1'b0;
		end
		else
		begin
			alarm_reg <= alarm_next;
			warn_reg <= warn_next;
			tick_reg <= tick ? '0 : tick_reg + 1'b1;
			edge_reg <= {keyLvl || inLvl, failLvl, doneLvl};
			ser_reg <= serNext;
			opt_reg <= optNext;
			adapt_reg <= adapt_next;
			cause_reg <= cause_next;
			refused_reg <= refused_next;
		end
	end
endmodule

// file: test/drive_fault_supervisor_assertions.sv
// port-level assertions for the fault supervisor
`timescale 1ns/1ps
module fault_supervisor_checker (
	input wire logic clock,
	input wire logic rstn,
	input wire logic earthFault,
	input wire logic outputShort,
	input wire logic powerNvmFault,
	input wire logic controlNvmFault,
	input wire logic driveEnable,
	input wire logic rampDown,
	input wire logic adaptRun,
	input wire logic [15:0] warnings,
	input wire logic [15:0] alarms
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rstn);
	AST_EARTH: assert property ($rose(earthFault) |-> ##[2:3] alarms[7])
		else $error("earth alarm missing");
	AST_SHORT: assert property ($rose(outputShort) |-> ##[2:3] alarms[8])
		else $error("short alarm missing");
	// serial and option alarms keep the stage on while ramping, so they are masked out
	AST_TRIP_OFF: assert property ((alarms & 16'h79ff) != 16'h0000 |-> !driveEnable)
		else $error("output stage on during trip");
	AST_LOCKED: assert property (alarms[7] |=> alarms[7])
		else $error("locked alarm cleared");
	AST_PNVM: assert property ($rose(powerNvmFault) |-> ##[2:4] warnings[11])
		else $error("power memory warning missing");
	AST_CNVM: assert property ($rose(controlNvmFault) |-> ##[2:4] warnings[12])
		else $error("control memory warning missing");
	AST_RAMP_ALARM: assert property ($rose(rampDown) |-> ##[0:1] (alarms[10:9] != 2'b00))
		else $error("ramp without timeout alarm");
	AST_RAMP_TRIP: assert property ($fell(rampDown) |-> ##[0:1] !driveEnable)
		else $error("no trip after ramp");
	AST_ADAPT_CLEAN: assert property ($rose(adaptRun) |-> $past(alarms) == 16'h0000)
		else $error("adaptation started with alarm");
endmodule
bind drive_fault_supervisor fault_supervisor_checker u_fault_supervisor_checker (.clock(clock), .rstn(rstn),
	.earthFault(earthFault), .outputShort(outputShort), .powerNvmFault(powerNvmFault),
	.controlNvmFault(controlNvmFault), .driveEnable(driveEnable), .rampDown(rampDown), .adaptRun(adaptRun),
	.warnings(warnings), .alarms(alarms));

// file: test/power_stage_model.sv
// ramp generator and adaptation engine answering the supervisor
`timescale 1ns/1ps
module power_stage_model (
	input wire logic clock,
	input wire logic rampDown,
	input wire logic adaptRun,
	input wire logic failMode,
	input wire logic [3:0] code,
	input wire logic [7:0] delay,
	output logic rampDone,
	output logic adaptDone,
	output logic adaptFail,
	output fault_pkg::adapt_code_t adaptResult
);
	import fault_pkg::*;
	logic [7:0] rampCnt = '0, adaptCnt = '0;
	always @(posedge clock)
	begin
		rampCnt <= rampDown ? rampCnt + 8'h01 : 8'h00;
		adaptCnt <= adaptRun ? adaptCnt + 8'h01 : 8'h00;
	end
	assign rampDone = rampDown && rampCnt >= delay;
	assign adaptFail = adaptRun && failMode && adaptCnt >= delay;
	assign adaptDone = adaptRun && !failMode && adaptCnt >= delay;
	// the code is only meaningful with the fail strobe; otherwise show garbage
	assign adaptResult = adapt_code_t'(adaptFail ? code : ~code);
endmodule

// file: test/tb_top.sv
// self-checking bench for the fault supervisor
`timescale 1ns/1ps
`include "fault_defs.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin bad_count++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
	import fault_pkg::*;
	localparam int TICK = 10;
	logic clock = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, errv;
	logic [7:0] paddr = '0, invThermal = '0, motorThermal = '0, heatsinkTemp = 8'h19, mdelay = 8'h02;
	logic [31:0] pwdata = '0, prdata, rdv;
	logic [11:0] busVoltage = 12'h0f0;
	logic [15:0] outputCurrent = '0, peakCurrent = '0, warnings, alarms;
	logic thermistorOpen = '0, earthFault = '0, outputShort = '0, phaseUMissing = '0, phaseVMissing = '0;
	logic powerNvmFault = '0, controlNvmFault = '0, resetKey = '0, resetInput = '0, failMode = '0;
	logic serialActivity = 1'b1, optionActivity = 1'b1, rampDone, adaptDone, adaptFail, driveEnable, rampDown, adaptRun;
	logic [3:0] code = '0;
	adapt_code_t adaptResult, adaptCause;
	int bad_count = 0, cmp_count = 0, waited, c, k;
	always #5 clock = ~clock;
	drive_fault_supervisor #(.TICK_CYCLES(TICK), .OV_DELAY(16'h0003), .UV_DELAY(16'h0003), .OC_DELAY(16'h0004))
	u_drive_fault_supervisor (.clock, .rstn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
		.busVoltage, .outputCurrent, .peakCurrent, .invThermal, .motorThermal, .heatsinkTemp, .thermistorOpen,
		.earthFault, .outputShort, .phaseUMissing, .phaseVMissing, .powerNvmFault, .controlNvmFault,
		.serialActivity, .optionActivity, .resetKey, .resetInput, .rampDone, .adaptDone, .adaptFail, .adaptResult,
		.driveEnable, .rampDown, .adaptRun, .adaptCause, .warnings, .alarms);
	power_stage_model u_power_stage_model (.clock, .rampDown, .adaptRun, .failMode, .code, .delay(mdelay),
		.rampDone, .adaptDone, .adaptFail, .adaptResult);
	task st(input int n);
		repeat (n) @(posedge clock);
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask
	task clr();
		apb(1'b1, `OFS_CMD, 32'h0000_0001);
		st(3);
	endtask
	task pulse(input int which);
		if (which == 1)
			resetInput <= 1'b1;
		else
			resetKey <= 1'b1;
		st(4);
		resetKey <= 1'b0;
		resetInput <= 1'b0;
		st(6);
	endtask
	task waitAl(input int i);
		waited = 0;
		while (alarms[i] !== 1'b1 && waited < 500)
		begin
			@(posedge clock);
			waited++;
		end
	endtask
	// kinds: 0 trip low, 1 warn low, 2 warn high, 3 trip high
	function automatic logic [11:0] lim(input int kind, input int cls);
		logic [11:0] t [12];
		t = '{12'h0d3, 12'h192, 12'h22d, 12'h0de, 12'h1a7, 12'h249, 12'h180, 12'h301, 12'h3af, 12'h1a9, 12'h357, 12'h3cf};
		return t[kind * 3 + cls];
	endfunction
	task stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		repeat (40000) @(posedge clock);
		bad_count++;
		stop_test();
	end
	initial
	begin
		void'($urandom(32'hfb88_181f));
		st(4);
		rstn <= 1'b1;
		st(4);
		apb(1'b0, 8'h40, 32'h0000_0000);
		`CHK({errv, rdv}, 33'h1_0000_0000)
		for (c = 0; c < 3; c++)
		begin
			apb(1'b1, `OFS_CONFIG, 32'(c));
			busVoltage <= lim(3, c);
			st(60);
			`CHK({warnings[7], alarms}, 17'h1_0000)
			busVoltage <= lim(3, c) + 12'h001;
			waitAl(0);
			`CHK(alarms[0], 1'b1)
			`CHK(waited >= 2 * TICK, 1'b1)
			busVoltage <= lim(1, c) + 12'h001 + 12'($urandom % 32'(lim(2, c) - lim(1, c) - 12'h002));
			st(8);
			`CHK({warnings[8:0], alarms[0]}, 10'h001)
			clr();
			`CHK(alarms, 16'h0000)
			busVoltage <= lim(0, c);
			st(60);
			`CHK({warnings[8], alarms}, 17'h1_0000)
			busVoltage <= lim(0, c) - 12'h001;
			waitAl(1);
			`CHK(alarms[1], 1'b1)
			busVoltage <= lim(2, c) - 12'h001;
			st(8);
			clr();
			`CHK(alarms, 16'h0000)
		end
		invThermal <= 8'h62;
		st(8);
		`CHK({warnings[2], alarms}, 17'h1_0000)
		invThermal <= 8'h64;
		st(8);
		`CHK({alarms[2], driveEnable}, 2'b10)
		invThermal <= 8'h5a;
		st(8);
		pulse(0);
		`CHK(alarms[2], 1'b1)
		invThermal <= 8'h59;
		st(8);
		pulse(0);
		`CHK(alarms, 16'h0000)
		busVoltage <= 12'h0f0;
		apb(1'b1, `OFS_CONFIG, 32'h0000_0008);
		heatsinkTemp <= 8'h4f;
		st(8);
		`CHK(alarms, 16'h0000)
		heatsinkTemp <= 8'h50;
		st(8);
		`CHK(alarms[12], 1'b1)
		apb(1'b1, `OFS_CONFIG, 32'h0000_0000);
		heatsinkTemp <= 8'h3c;
		st(8);
		pulse(1);
		`CHK(alarms[12], 1'b1)
		heatsinkTemp <= 8'h3b;
		st(8);
		pulse(1);
		`CHK(alarms, 16'h0000)
		heatsinkTemp <= 8'h59;
		st(8);
		`CHK(alarms, 16'h0000)
		heatsinkTemp <= 8'h5a;
		st(8);
		`CHK(alarms[12], 1'b1)
		heatsinkTemp <= 8'h19;
		st(4);
		pulse(1);
		for (k = 0; k < 2; k++)
		begin
			apb(1'b1, `OFS_CONFIG, 32'(k * 4));
			motorThermal <= 8'h64;
			thermistorOpen <= 1'b1;
			st(8);
			`CHK(alarms[4:3], k ? 2'b11 : 2'b00)
			`CHK(alarms[4:3] | warnings[4:3], 2'b11)
			motorThermal <= 8'h00;
			thermistorOpen <= 1'b0;
			st(4);
			clr();
		end
		phaseUMissing <= 1'b1;
		st(8);
		`CHK(alarms, 16'h2000)
		phaseUMissing <= 1'b0;
		st(4);
		clr();
		apb(1'b1, `OFS_CONFIG, 32'h0000_0400);
		phaseVMissing <= 1'b1;
		st(8);
		`CHK(alarms, 16'h4000)
		phaseVMissing <= 1'b0;
		st(40);
		`CHK(alarms, 16'h0000)
		apb(1'b1, `OFS_CONFIG, 32'h0000_0000);
		powerNvmFault <= 1'b1;
		controlNvmFault <= 1'b1;
		st(8);
		`CHK({warnings[12:11], alarms, driveEnable}, 19'h6_0001)
		powerNvmFault <= 1'b0;
		controlNvmFault <= 1'b0;
		st(8);
		`CHK(warnings, 16'h0000)
		apb(1'b1, `OFS_ILIM, 32'h0000_0064);
		apb(1'b1, `OFS_ILIM_DELAY, 32'h0000_0003);
		outputCurrent <= 16'h0064;
		st(60);
		`CHK({warnings[5], alarms}, 17'h0_0000)
		outputCurrent <= 16'h0065;
		st(8);
		`CHK(warnings[5], 1'b1)
		waitAl(5);
		`CHK(alarms[5], 1'b1)
		outputCurrent <= 16'h0000;
		st(4);
		clr();
		apb(1'b1, `OFS_RATED, 32'h0032_003c);
		peakCurrent <= 16'h0064;
		st(60);
		`CHK(alarms, 16'h0000)
		peakCurrent <= 16'h0065;
		st(8);
		`CHK(warnings[6], 1'b1)
		waitAl(6);
		`CHK(alarms[6], 1'b1)
		peakCurrent <= 16'h0000;
		earthFault <= 1'b1;
		st(8);
		earthFault <= 1'b0;
		outputShort <= 1'b1;
		st(8);
		outputShort <= 1'b0;
		st(4);
		`CHK(warnings, 16'h0000)
		clr();
		`CHK(alarms, 16'h01c0)
		rstn <= 1'b0;
		st(4);
		rstn <= 1'b1;
		st(4);
		`CHK({alarms, driveEnable}, 17'h0_0001)
		apb(1'b1, `OFS_SER_TMO, 32'h0000_0003);
		apb(1'b1, `OFS_OPT_TMO, 32'h0000_0003);
		serialActivity <= 1'b0;
		optionActivity <= 1'b0;
		st(60);
		`CHK({warnings[10:9], alarms}, 18'h0_0000)
		apb(1'b1, `OFS_CONFIG, 32'h0000_0090);
		st(60);
		`CHK({warnings[10:9], alarms}, 18'h3_0000)
		for (k = 0; k < 2; k++)
		begin
			mdelay <= k ? 8'h28 : 8'h02;
			serialActivity <= (k != 0);
			optionActivity <= (k == 0);
			apb(1'b1, `OFS_CONFIG, 32'h0000_0005 << (k * 3 + 4));
			waitAl(9 + k);
			st(2);
			`CHK({alarms[9 + k], rampDown, driveEnable}, 3'b111)
			waited = 0;
			while (driveEnable !== 1'b0 && waited < 300)
			begin
				@(posedge clock);
				waited++;
			end
			`CHK({driveEnable, rampDown}, 2'b00)
			serialActivity <= 1'b1;
			optionActivity <= 1'b1;
			st(4);
			clr();
			`CHK(alarms, 16'h0000)
		end
		apb(1'b1, `OFS_RATED, 32'h0064_0023);
		apb(1'b1, `OFS_CMD, 32'h0000_0002);
		st(4);
		`CHK({alarms[11], adaptRun, adaptCause}, {2'b10, CAUSE_LOW_CURRENT})
		clr();
		apb(1'b1, `OFS_RATED, 32'h0064_0024);
		failMode <= 1'b1;
		mdelay <= 8'h03;
		for (k = 0; k < 10; k++)
		begin
			code <= 4'(k);
			apb(1'b1, `OFS_CMD, 32'h0000_0002);
			waitAl(11);
			`CHK({alarms[11], adaptRun, adaptCause}, {2'b10, 4'(k)})
			clr();
		end
		failMode <= 1'b0;
		apb(1'b1, `OFS_CMD, 32'h0000_0002);
		st(2);
		`CHK(adaptRun, 1'b1)
		st(20);
		`CHK({adaptRun, alarms}, 17'h0_0000)
		phaseUMissing <= 1'b1;
		st(8);
		apb(1'b1, `OFS_CMD, 32'h0000_0002);
		st(3);
		apb(1'b0, `OFS_ADAPT, 32'h0000_0000);
		`CHK({adaptRun, rdv[4]}, 2'b01)
		phaseUMissing <= 1'b0;
		st(4);
		clr();
		stop_test();
	end
endmodule
